// ### rtl/sdf_consts.svh
// Purpose: constants for the sensor diagnostics and flags block
// Assumes: 25 MHz system clock
// Notes:   offsets, field positions, reset values and timing counts
`ifndef SDF_CONSTS_SVH
`define SDF_CONSTS_SVH

// ==========================================================
// Timing
`define SDF_CLK_HZ            25000000
`define SDF_SELF_TEST_MS      30
`define SDF_SELF_TEST_CYC     ((`SDF_CLK_HZ / 1000) * `SDF_SELF_TEST_MS)

// ==========================================================
// Logic self-test geometry
`define SDF_NUM_CHAINS        31
`define SDF_LFSR_W            31
`define SDF_MISR_W            31
`define SDF_CHAIN_LEN         16
`define SDF_LFSR_SEED         31'h0000_0001
`define SDF_MISR_SEED         31'h0000_0000
`define SDF_GOLDEN_SIG        31'h1234_5678

// ==========================================================
// Field thresholds
`define SDF_THR_W             6
`define SDF_FIELD_W           12
`define SDF_HI_STEP_G         32
`define SDF_LO_STEP_G         16
`define SDF_HI_THR_RST        6'h25
`define SDF_LO_THR_RST        6'h0D

// ==========================================================
// Angles, 4096 codes per turn
`define SDF_ANGLE_W           12
`define SDF_WAKE_TRAVEL_CODES 12'h600
`define SDF_WAKE_THR_W        11
`define SDF_WAKE_THR_RST      11'h29F
`define SDF_TURNS_MAX         9'h100

// ==========================================================
// Angle register
`define SDF_ANGLE_ADDR        8'h20

// ==========================================================
// Error register bit positions
`define SDF_ERR_W             12
`define SDF_E_STF             0
`define SDF_E_UVD             1
`define SDF_E_MSL             2
`define SDF_E_OFE             3
`define SDF_E_EUE             4
`define SDF_E_PLK             5
`define SDF_E_ZIE             6
`define SDF_E_RST             7
`define SDF_E_ENC             8
`define SDF_E_UVA             9
`define SDF_E_AVG             10
// Warning register bit positions
`define SDF_WARN_W            8
`define SDF_W_MSH             0
`define SDF_W_ESE             1
`define SDF_W_TOV             2
`define SDF_W_TCW             3
`define SDF_W_FMT             4
`define SDF_W_CRC             5
`define SDF_W_TMP             6

`endif

// ### rtl/sdf_pkg.sv
// Purpose: types for the sensor diagnostics and flags block
// Assumes: sdf_consts.svh
// Notes:   event and report bundles
package sdf_pkg;
`include "sdf_consts.svh"

	// ==========================================================
	// Raw fault events from the sensor core
	typedef struct packed {
		logic supply_low;
		logic osc_mismatch;
		logic ecc_single;
		logic ecc_multi;
		logic pll_unlock;
		logic zero_cross_bad;
		logic power_lost;
		logic analog_drift;
		logic temp_out;
		logic spi_bad_count;
		logic spi_msb_set;
		logic spi_crc_bad;
	} sdf_events_t;

	// ==========================================================
	// Summary bits for the angle register
	typedef struct packed {
		logic general_error_bit;
		logic undervolt_summary_bit;
	} sdf_summary_t;

	typedef enum {SDF_IDLE, SDF_RUN, SDF_DONE} sdf_bist_state_t;
endpackage : sdf_pkg

// ### rtl/sdf_lbist.sv
// Purpose: logic self-test, 31 scan chains, LFSR source, MISR sink
// Assumes: chain outputs arrive from the scanned logic
// Notes:   signature compared to a golden value at the end
`timescale 1ns/10ps
`include "sdf_consts.svh"
module sdf_lbist #(
	parameter int CHAINS = `SDF_NUM_CHAINS,
	parameter int LEN    = `SDF_CHAIN_LEN
) (
	// Clock and reset
	input  wire logic              sys_clk_in,
	input  wire logic              rst_in,
	// Control
	input  wire logic              start_in,
	// Scan
	output logic [CHAINS-1:0]      scan_in_out,
	input  wire logic [CHAINS-1:0] scan_out_in,
	// Result
	output logic                   done_out,
	output logic                   fail_out
);
	import sdf_pkg::*;

	initial begin
		if (CHAINS != `SDF_LFSR_W || LEN < 1)
			$error("sdf_lbist: unsupported geometry");
	end

	typedef struct packed {
		logic [30:0] lfsr;
		logic [30:0] misr;
		logic [15:0] cnt;
		logic        busy;
		logic        done;
		logic        fail;
	} sdf_lb_t;

	sdf_lb_t s_q;
	sdf_lb_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (start_in && !s_q.busy) begin
			s_d.busy = 1'b1;
			s_d.lfsr = `SDF_LFSR_SEED;
			s_d.misr = `SDF_MISR_SEED;
			s_d.cnt  = 16'h0000;
		end else if (s_q.busy) begin
			// x^31 + x^28 + 1
			s_d.lfsr = {s_q.lfsr[29:0], s_q.lfsr[30] ^ s_q.lfsr[27]};
			s_d.misr = {s_q.misr[29:0], s_q.misr[30] ^ s_q.misr[27]} ^ scan_out_in;
			s_d.cnt  = s_q.cnt + 16'h0001;
			if (s_q.cnt == 16'(LEN - 1)) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.fail = (s_d.misr != `SDF_GOLDEN_SIG);
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign scan_in_out = s_q.lfsr;
	assign done_out    = s_q.done;
	assign fail_out    = s_q.fail;

	a_lb_len: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(start_in && !s_q.busy) |=> s_q.busy [*1] ##(LEN) s_q.done)
		else $error("lbist length wrong");
endmodule : sdf_lbist

// ### rtl/sdf_field_check.sv
// Purpose: field threshold comparison
// Assumes: field in gauss, code zero disables a check
// Notes:   registered flags
`timescale 1ns/10ps
`include "sdf_consts.svh"
module sdf_field_check (
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// Inputs
	input  wire logic [11:0] field_in,
	input  wire logic [5:0]  thr_hi_in,
	input  wire logic [5:0]  thr_lo_in,
	// Flags
	output logic             high_out,
	output logic             low_out
);
	import sdf_pkg::*;

	function automatic logic [11:0] sdf_scale(input logic [5:0] c, input int step);
		sdf_scale = 12'(int'(c) * step);
	endfunction : sdf_scale

	typedef struct packed {
		logic hi;
		logic lo;
	} sdf_fc_t;

	sdf_fc_t s_q;
	sdf_fc_t s_d;

	always_comb begin
		s_d.hi = (thr_hi_in != 6'h00) && (field_in > sdf_scale(thr_hi_in, `SDF_HI_STEP_G));
		s_d.lo = (thr_lo_in != 6'h00) && (field_in < sdf_scale(thr_lo_in, `SDF_LO_STEP_G));
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign high_out = s_q.hi;
	assign low_out  = s_q.lo;
endmodule : sdf_field_check

// ### rtl/sdf_diag.sv
// Function
// - Self-tests run at power-up or on command
// - Either self-test failing sets failure flag
// - Transducer self-test takes about 30 ms
// - 31 chains fed by 31-bit LFSR
// - MISR compresses chains into 31-bit signature
// - All flags readable by host
// - Unmasked error sets general error bit
// - Supply low sets undervolt and summary bits
// - Field above high threshold sets warning
// - Field below low threshold sets error
// - Oscillator mismatch sets error flag
// - EEPROM single-bit warns, multi-bit errors
// - PLL unlock or zero-cross failure flagged
// - Supply loss sets reset-indication bit
// - Skipped encoder state sets integrity bit
// - Regulator drift sets analog undervolt bits
// - Turns counter saturation sets overflow warning
// - Wake travel over 135 degrees warns
// - Stay awake while angle change exceeds threshold
// - Averaging span over two quadrants errors
// - Bad clock count or MSB warns
// - Checksum failure warns in 20-bit frames when checking enabled
//
// Purpose: diagnostic flags and self-test sequencing
// Assumes: sensor core supplies events as one-cycle pulses or levels
// Notes:   flags stick until host clear pulse; set wins over clear
`timescale 1ns/10ps
`include "sdf_consts.svh"
module sdf_diag #(
	parameter int ST_CYCLES = `SDF_SELF_TEST_CYC,
	parameter int CHAIN_LEN = `SDF_CHAIN_LEN
) (
	// Clock and reset
	input  wire logic                   sys_clk_in,
	input  wire logic                   rst_in,
	// Self-test configuration and command
	input  wire logic                   lbist_at_powerup_in,
	input  wire logic                   xdcr_at_powerup_in,
	input  wire logic                   self_test_disable_in,
	input  wire logic                   self_test_cmd_in,
	input  wire logic                   xdcr_pass_in,
	input  wire logic [30:0]            scan_out_in,
	output logic      [30:0]            scan_in_out,
	output logic                        self_test_busy_out,
	// Sensor events
	input  wire sdf_pkg::sdf_events_t   events_in,
	input  wire logic [11:0]            field_in,
	input  wire logic [5:0]             thr_hi_in,
	input  wire logic [5:0]             thr_lo_in,
	input  wire logic [11:0]            angle_in,
	input  wire logic                   angle_valid_in,
	input  wire logic [1:0]             enc_state_in,
	input  wire logic                   avg_start_in,
	input  wire logic                   turn_step_in,
	input  wire logic                   turns_clear_in,
	input  wire logic                   low_power_state_in,
	input  wire logic                   wake_sample_in,
	input  wire logic [10:0]            wake_angle_threshold_in,
	input  wire logic                   checksum_check_enable_in,
	input  wire logic                   frame_20bit_in,
	// Host access
	input  wire logic [11:0]            err_mask_in,
	input  wire logic [7:0]             warn_mask_in,
	input  wire logic                   flag_clear_in,
	output logic      [11:0]            err_flags_out,
	output logic      [7:0]             warn_flags_out,
	output sdf_pkg::sdf_summary_t       summary_out,
	output logic                        stay_awake_out,
	output logic      [8:0]             turns_out
);
	import sdf_pkg::*;

	initial begin
		if (ST_CYCLES < 1 || CHAIN_LEN < 1)
			$error("sdf_diag: counts must be positive");
	end

	// ==========================================================
	// Helpers
	function automatic logic [11:0] sdf_adiff(input logic [11:0] a, input logic [11:0] b);
		logic [11:0] d;
		d = a - b;
		sdf_adiff = d[11] ? 12'(-d) : d;
	endfunction : sdf_adiff

	// ==========================================================
	// State
	typedef struct packed {
		sdf_bist_state_t st;
		logic [31:0]     st_cnt;
		logic            pwrup_done;
		logic            lb_fail;
		logic [11:0]     err;
		logic [7:0]      warn;
		sdf_summary_t    sum;
		logic [1:0]      enc_prev;
		logic [11:0]     wake_prev;
		logic            wake_seen;
		logic            awake;
		logic [11:0]     avg_first;
		logic [1:0]      avg_quads;
		logic            avg_on;
		logic [8:0]      turns;
	} sdf_diag_t;

	sdf_diag_t s_q;
	sdf_diag_t s_d;

	logic        lb_start;
	logic        lb_done;
	logic        lb_fail;
	logic        f_hi;
	logic        f_lo;
	logic [11:0] err_set;
	logic [7:0]  warn_set;
	logic [11:0] wdiff;
	logic [1:0]  qdist;
	logic [1:0]  qnow;
	logic        enc_skip;

	// ==========================================================
	// Submodules
	sdf_lbist #(
		.CHAINS (`SDF_NUM_CHAINS),
		.LEN    (CHAIN_LEN)
	) u_lbist (
		.sys_clk_in  (sys_clk_in),
		.rst_in      (rst_in),
		.start_in    (lb_start),
		.scan_in_out (scan_in_out),
		.scan_out_in (scan_out_in),
		.done_out    (lb_done),
		.fail_out    (lb_fail)
	);

	sdf_field_check u_field (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.field_in   (field_in),
		.thr_hi_in  (thr_hi_in),
		.thr_lo_in  (thr_lo_in),
		.high_out   (f_hi),
		.low_out    (f_lo)
	);

	// ==========================================================
	// Event decode
	always_comb begin
		wdiff    = sdf_adiff(angle_in, s_q.wake_prev);
		qnow     = angle_in[11:10];
		qdist    = qnow - s_q.avg_first[11:10];
		enc_skip = (enc_state_in[0] != s_q.enc_prev[0]) && (enc_state_in[1] != s_q.enc_prev[1]);
		lb_start = 1'b0;
		if (s_q.st == SDF_IDLE) begin
			if (!s_q.pwrup_done && (lbist_at_powerup_in || xdcr_at_powerup_in))
				lb_start = lbist_at_powerup_in;
			else if (self_test_cmd_in && !self_test_disable_in)
				lb_start = 1'b1;
		end
		err_set = '0;
		err_set[`SDF_E_UVD] = events_in.supply_low;
		err_set[`SDF_E_MSL] = f_lo;
		err_set[`SDF_E_OFE] = events_in.osc_mismatch;
		err_set[`SDF_E_EUE] = events_in.ecc_multi;
		err_set[`SDF_E_PLK] = events_in.pll_unlock;
		err_set[`SDF_E_ZIE] = events_in.zero_cross_bad;
		err_set[`SDF_E_RST] = events_in.power_lost;
		err_set[`SDF_E_ENC] = enc_skip;
		err_set[`SDF_E_UVA] = events_in.analog_drift;
		err_set[`SDF_E_AVG] = angle_valid_in && s_q.avg_on && (qdist == 2'h2);
		err_set[`SDF_E_STF] = (s_q.st == SDF_RUN) && s_q.st_cnt == 32'h0
			&& (s_q.lb_fail || !xdcr_pass_in);
		warn_set = '0;
		warn_set[`SDF_W_MSH] = f_hi;
		warn_set[`SDF_W_ESE] = events_in.ecc_single;
		warn_set[`SDF_W_TOV] = turn_step_in && (s_q.turns == `SDF_TURNS_MAX);
		warn_set[`SDF_W_TCW] = low_power_state_in && wake_sample_in && s_q.wake_seen
			&& (wdiff > `SDF_WAKE_TRAVEL_CODES);
		warn_set[`SDF_W_FMT] = events_in.spi_bad_count || events_in.spi_msb_set;
		warn_set[`SDF_W_CRC] = frame_20bit_in && checksum_check_enable_in && events_in.spi_crc_bad;
		warn_set[`SDF_W_TMP] = events_in.temp_out;
	end

	// ==========================================================
	// Next state
	always_comb begin
		s_d = s_q;
		// Self-test sequencer
		case (s_q.st)
			SDF_IDLE: begin
				if ((!s_q.pwrup_done && (lbist_at_powerup_in || xdcr_at_powerup_in))
					|| (self_test_cmd_in && !self_test_disable_in)) begin
					s_d.st      = SDF_RUN;
					s_d.st_cnt  = 32'(ST_CYCLES - 1);
					s_d.lb_fail = 1'b0;
				end
				s_d.pwrup_done = 1'b1;
			end
			SDF_RUN: begin
				if (lb_done)
					s_d.lb_fail = lb_fail;
				if (s_q.st_cnt == 32'h0)
					s_d.st = SDF_DONE;
				else
					s_d.st_cnt = s_q.st_cnt - 32'h1;
			end
			SDF_DONE: s_d.st = SDF_IDLE;
			default:  s_d.st = SDF_IDLE;
		endcase

		// Sticky flags, set wins over clear
		s_d.err  = (flag_clear_in ? '0 : s_q.err) | err_set;
		s_d.warn = (flag_clear_in ? '0 : s_q.warn) | warn_set;
		s_d.err[11] = 1'b0;
		s_d.warn[7] = 1'b0;

		// Turns counter, saturating
		if (turns_clear_in)
			s_d.turns = 9'h000;
		else if (turn_step_in && s_q.turns != `SDF_TURNS_MAX)
			s_d.turns = s_q.turns + 9'h001;

		// Encoder history
		s_d.enc_prev = enc_state_in;

		// Wake tracking
		if (!low_power_state_in) begin
			s_d.wake_seen = 1'b0;
			s_d.awake     = 1'b0;
		end else if (wake_sample_in) begin
			s_d.wake_prev = angle_in;
			s_d.wake_seen = 1'b1;
			s_d.awake     = s_q.wake_seen && (wdiff > {1'b0, wake_angle_threshold_in});
		end

		// Averaging window
		if (avg_start_in) begin
			s_d.avg_first = angle_in;
			s_d.avg_on    = 1'b1;
		end

		// Summary, from the flags about to be registered
		s_d.sum.general_error_bit = |(s_d.err & ~err_mask_in) | |(s_d.warn & ~warn_mask_in);
		s_d.sum.undervolt_summary_bit = (s_d.err[`SDF_E_UVD] & ~err_mask_in[`SDF_E_UVD])
			| (s_d.err[`SDF_E_UVA] & ~err_mask_in[`SDF_E_UVA]);
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// ==========================================================
	// Outputs
	assign err_flags_out      = s_q.err;
	assign warn_flags_out     = s_q.warn;
	assign summary_out        = s_q.sum;
	assign self_test_busy_out = (s_q.st == SDF_RUN);
	assign stay_awake_out     = s_q.awake;
	assign turns_out          = s_q.turns;

	// ==========================================================
	// Checks
	a_st_fail: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		err_set[`SDF_E_STF] |=> s_q.err[`SDF_E_STF])
		else $error("self-test failure not flagged");
	a_st_start: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(s_q.st == SDF_IDLE && self_test_cmd_in && !self_test_disable_in) |=> s_q.st == SDF_RUN)
		else $error("self-test command ignored");
	a_uvd_flag: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		events_in.supply_low |=> s_q.err[`SDF_E_UVD])
		else $error("undervolt not flagged");
	a_gen_err: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		summary_out.general_error_bit == (|(s_q.err & ~$past(err_mask_in)) | |(s_q.warn & ~$past(warn_mask_in))))
		else $error("general error mismatch");
	a_osc_flag: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		events_in.osc_mismatch |=> s_q.err[`SDF_E_OFE])
		else $error("oscillator flag missing");
	a_tov_sat: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		s_q.turns <= `SDF_TURNS_MAX)
		else $error("turns counter overran");
	a_fmt_flag: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		events_in.spi_msb_set |=> s_q.warn[`SDF_W_FMT])
		else $error("frame error not flagged");
	a_crc_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(!checksum_check_enable_in && !s_q.warn[`SDF_W_CRC]) |=> !s_q.warn[`SDF_W_CRC])
		else $error("checksum flag set while disabled");
	c_self_test: cover property (@(posedge sys_clk_in) s_q.st == SDF_RUN ##1 s_q.st == SDF_DONE);
	c_gen_err:   cover property (@(posedge sys_clk_in) summary_out.general_error_bit);
	c_awake:     cover property (@(posedge sys_clk_in) stay_awake_out);
endmodule : sdf_diag

// ### verification/sdf_scan_model.sv
// Purpose: scanned logic seen by the logic self-test
// Assumes: one stage per chain bit, shifted every cycle
// Notes:   output mixes neighbouring chains so the signature moves
`timescale 1ns/10ps
module sdf_scan_model #(
	parameter int LEN = 16
) (
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// Chains
	input  wire logic [30:0] chain_fill_in,
	output logic      [30:0] chain_tap_out
);
	logic [30:0] stage_q [LEN];

	// ==========================================================
	// 31 chains of LEN stages, loaded in parallel
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < LEN; i++) stage_q[i] <= 31'h0000_0000;
		end else begin
			stage_q[0] <= chain_fill_in;
			for (int i = 1; i < LEN; i++) stage_q[i] <= stage_q[i-1] ^ {stage_q[i-1][29:0], 1'b0};
		end
	end

	// Chain outputs towards the signature register
	assign chain_tap_out = stage_q[LEN-1];
endmodule : sdf_scan_model

// ### verification/sensor_diagnostics_and_flags_tb.sv
// Purpose: self-checking bench for the diagnostic flags block
// Assumes: self-test shortened to 50 cycles
// Notes:   drives at the rising edge, samples 1 ns later
`timescale 1ns/10ps
`include "sdf_consts.svh"
module sensor_diagnostics_and_flags_tb;
	import sdf_pkg::*;
	localparam int ST = 50;
	logic               sys_clk_in = 1'b0;
	logic               rst_in = 1'b1;
	logic               lbist_pu = 1'b1, xdcr_pu = 1'b1, st_dis = 1'b0, st_cmd = 1'b0, xdcr_pass = 1'b0;
	logic [30:0]        scan_fill, scan_tap;
	logic               busy;
	sdf_events_t        ev = '0;
	logic [11:0]        field = 12'h000, angle = 12'h000;
	logic [5:0]         thr_hi = 6'h00, thr_lo = 6'h00;
	logic               ang_vld = 1'b0, avg_start = 1'b0, turn_step = 1'b0, turns_clr = 1'b0;
	logic               lp_state = 1'b0, wake_smp = 1'b0, crc_en = 1'b0, f20 = 1'b0, clr = 1'b0;
	logic [1:0]         enc = 2'h0;
	logic [11:0]        err_mask = 12'h000, err_f;
	logic [7:0]         warn_mask = 8'h00, warn_f;
	sdf_summary_t       summ;
	logic               awake;
	logic [8:0]         turns;
	int                 errors = 0;
	int                 check_count = 0;
	int                 n;
	logic [19:0]        exp_t [12];
	logic               uv_t [12];

	always #20 sys_clk_in = ~sys_clk_in;

	sdf_scan_model #(.LEN(16)) model_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .chain_fill_in(scan_fill),
		.chain_tap_out(scan_tap));

	sdf_diag #(.ST_CYCLES(ST), .CHAIN_LEN(16)) dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.lbist_at_powerup_in(lbist_pu), .xdcr_at_powerup_in(xdcr_pu), .self_test_disable_in(st_dis),
		.self_test_cmd_in(st_cmd), .xdcr_pass_in(xdcr_pass), .scan_out_in(scan_tap), .scan_in_out(scan_fill),
		.self_test_busy_out(busy), .events_in(ev), .field_in(field), .thr_hi_in(thr_hi), .thr_lo_in(thr_lo),
		.angle_in(angle), .angle_valid_in(ang_vld), .enc_state_in(enc), .avg_start_in(avg_start),
		.turn_step_in(turn_step), .turns_clear_in(turns_clr), .low_power_state_in(lp_state),
		.wake_sample_in(wake_smp), .wake_angle_threshold_in(`SDF_WAKE_THR_RST),
		.checksum_check_enable_in(crc_en), .frame_20bit_in(f20), .err_mask_in(err_mask),
		.warn_mask_in(warn_mask), .flag_clear_in(clr), .err_flags_out(err_f), .warn_flags_out(warn_f),
		.summary_out(summ), .stay_awake_out(awake), .turns_out(turns));

	// ==========================================================
	// Helpers
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk_in);
	endtask : cyc

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic clear_flags();
		cyc(1);
		clr <= 1'b1;
		cyc(1);
		clr <= 1'b0;
		cyc(1);
		#1 chk({warn_f, err_f, summ}, 22'h0, "flags after clear");
	endtask : clear_flags

	// Waits up to 8 cycles for every bit of m in {warn, err}
	task automatic wait_hi(input logic [19:0] m, input string what);
		n = 0;
		#1 while ((({warn_f, err_f} & m) !== m) && n < 8) begin
			cyc(1);
			#1 n++;
		end
		chk({warn_f, err_f} & m, m, what);
	endtask : wait_hi

	task automatic count_busy(input int exp_n);
		n = 0;
		while (busy === 1'b1 && n < 2 * ST) begin
			cyc(1);
			#1 n++;
		end
		chk(n, exp_n, "busy length");
	endtask : count_busy

	task automatic field_case(input logic [5:0] hi, input logic [5:0] lo, input logic [11:0] ok,
		input logic [11:0] bad, input logic [19:0] m);
		cyc(1);
		thr_hi <= hi;
		thr_lo <= lo;
		field <= ok;
		cyc(4);
		clear_flags();
		cyc(4);
		#1 chk({warn_f, err_f} & m, 20'h0, "field at limit");
		cyc(1);
		field <= bad;
		cyc(1);
		wait_hi(m, "field beyond limit");
		thr_hi <= 6'h00;
		thr_lo <= 6'h00;
		cyc(2);
		clear_flags();
	endtask : field_case

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		#(40 * 20000);
		errors++;
		report_and_stop();
	end

	// ==========================================================
	// Tests
	initial begin
		// Event to flag table: {warn, err}
		exp_t = '{20'h00002, 20'h00008, 20'h02000, 20'h00010, 20'h00020, 20'h00040,
			20'h00080, 20'h00200, 20'h40000, 20'h10000, 20'h10000, 20'h20000};
		uv_t = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		cyc(10);
		rst_in <= 1'b0;
		cyc(1);
		#1 chk(busy, 1'b1, "power-up test started");
		count_busy(ST);
		chk(err_f[`SDF_E_STF], 1'b1, "failed test flag");
		chk(summ.general_error_bit, 1'b1, "summary of test failure");
		$display("Test power_up done");
		clear_flags();
		cyc(1);
		st_dis <= 1'b1;
		st_cmd <= 1'b1;
		cyc(1);
		st_cmd <= 1'b0;
		cyc(2);
		#1 chk(busy, 1'b0, "disabled command refused");
		st_dis <= 1'b0;
		st_cmd <= 1'b1;
		cyc(1);
		st_cmd <= 1'b0;
		#1 chk(busy, 1'b1, "command starts tests");
		cyc(10);
		st_cmd <= 1'b1;
		cyc(1);
		st_cmd <= 1'b0;
		#1 count_busy(ST - 11);
		chk(n, ST - 11, "command during run ignored");
		chk(err_f[`SDF_E_STF], 1'b1, "failed command test");
		$display("Test command done");
		clear_flags();
		crc_en <= 1'b1;
		f20 <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			for (int m = 0; m < 2; m++) begin
				err_mask <= m ? 12'hFFF : 12'h000;
				warn_mask <= m ? 8'hFF : 8'h00;
				ev <= 12'h800 >> i;
				cyc(1);
				ev <= '0;
				cyc(1);
				#1 chk({warn_f, err_f}, exp_t[i], "event flag");
				chk(summ.general_error_bit, !m, "general error and mask");
				if (!m) chk(summ.undervolt_summary_bit, uv_t[i], "undervolt summary");
				clear_flags();
			end
		end
		err_mask <= 12'h000;
		warn_mask <= 8'h00;
		crc_en <= 1'b0;
		ev <= 12'h001;
		cyc(1);
		ev <= '0;
		cyc(1);
		#1 chk(warn_f, 8'h00, "checksum ignored when disabled");
		$display("Test events done");
		field_case(6'h01, 6'h00, 12'd32, 12'd33, 20'h01000);
		field_case(6'h00, 6'h0D, 12'd208, 12'd207, 20'h00004);
		$display("Test field done");
		enc <= 2'h1;
		cyc(3);
		clear_flags();
		enc <= 2'h2;
		cyc(1);
		wait_hi(20'h00100, "encoder skip");
		clear_flags();
		for (int i = 0; i < 256; i++) begin
			turn_step <= 1'b1;
			cyc(1);
			turn_step <= 1'b0;
			cyc(1);
		end
		#1 chk(turns, `SDF_TURNS_MAX, "turns saturated");
		chk(warn_f[`SDF_W_TOV], 1'b0, "no overflow at 256");
		turn_step <= 1'b1;
		cyc(1);
		turn_step <= 1'b0;
		cyc(1);
		#1 chk(warn_f[`SDF_W_TOV], 1'b1, "overflow past 256");
		clear_flags();
		lp_state <= 1'b1;
		wake_smp <= 1'b1;
		cyc(1);
		wake_smp <= 1'b0;
		angle <= 12'h700;
		cyc(2);
		wake_smp <= 1'b1;
		cyc(1);
		wake_smp <= 1'b0;
		wait_hi(20'h08000, "wake travel");
		chk(awake, 1'b1, "stays awake");
		lp_state <= 1'b0;
		angle <= 12'h000;
		avg_start <= 1'b1;
		cyc(1);
		avg_start <= 1'b0;
		angle <= 12'h800;
		ang_vld <= 1'b1;
		cyc(1);
		ang_vld <= 1'b0;
		wait_hi(20'h00400, "averaging span");
		$display("Test turns_and_wake done");
		report_and_stop();
	end
endmodule : sensor_diagnostics_and_flags_tb
